// *** jk_flip_flop_direct_clear.sv ***
`timescale 1ns/1ps
`default_nettype none
module jk_flip_flop_direct_clear
  import jk_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic steer_first_i,
  input wire logic steer_second_i,
  input wire logic toggle_clk_i,
  input wire logic direct_clear_i,
  output logic state_o,
  output logic state_n_o
);

  // ************************************************************
  // pin synchronisation
  // ************************************************************
  logic [3:0] pins_sync;
  steer_s steer;
  logic tclk_s;
  logic clr_s;

  jk_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i({steer_first_i, steer_second_i, toggle_clk_i, direct_clear_i}),
    .sync_o(pins_sync)
  );

  always_comb begin
    steer.first = pins_sync[3];
    steer.second = pins_sync[2];
    tclk_s = pins_sync[1];
    clr_s = pins_sync[0];
  end

  // ************************************************************
  // falling edge detection of the device clock
  // ************************************************************
  logic tclk_prev_q;
  logic tclk_prev_d;
  logic fall_edge;

  // the previous copy resets low like the synchronised copy, so the
  // idle-high pin shows only a harmless rising edge after reset
  always_comb begin
    tclk_prev_d = tclk_s;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tclk_prev_q <= 1'b0;
    end else begin
      tclk_prev_q <= tclk_prev_d;
    end
  end

  // (RQ2) falling edge only
  assign fall_edge = tclk_prev_q & ~tclk_s;

  // ************************************************************
  // steering decode and state
  // ************************************************************
  action_e act;
  logic state_q;
  logic state_d;

  // (RQ1) steering truth table
  always_comb begin
    case ({steer.first, steer.second})
      2'b11: act = ACT_HOLD;
      2'b10: act = ACT_SET;
      2'b01: act = ACT_RESET;
      2'b00: act = ACT_TOGGLE;
      default: act = ACT_HOLD;
    endcase
  end

  always_comb begin
    state_d = state_q;
    // (RQ6) clear has priority
    if (clr_s) begin
      // (RQ4) force cleared state
      state_d = 1'b0;
    end else if (fall_edge) begin
      // (RQ1) apply steering action
      case (act)
        ACT_HOLD: state_d = state_q;
        ACT_SET: state_d = 1'b1;
        ACT_RESET: state_d = 1'b0;
        // (RQ5) cleared state toggles to set
        ACT_TOGGLE: state_d = ~state_q;
        default: state_d = state_q;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= STATE_RESET_VAL;
    end else begin
      state_q <= state_d;
    end
  end

  // clear acts one clk_i edge after the sync latency, not on a device clock edge;
  // combinational bypass would break the flop-driven data outputs
  assign state_o = state_q;
  assign state_n_o = ~state_q;

  // ************************************************************
  // checks
  // ************************************************************
  // (RQ1) hold keeps state
  chk_hold_steer: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ1
    (!clr_s && fall_edge && steer.first && steer.second) |=> state_q == $past(state_q))
    else $error("hold did not keep state");

  // (RQ1) set drives high
  chk_set_steer: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ1
    (!clr_s && fall_edge && steer.first && !steer.second) |=> state_q)
    else $error("set did not set");

  // (RQ1) reset drives low
  chk_reset_steer: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ1
    (!clr_s && fall_edge && !steer.first && steer.second) |=> !state_q)
    else $error("reset did not reset");

  // (RQ1) toggle inverts state
  chk_toggle_steer: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ1
    (!clr_s && fall_edge && !steer.first && !steer.second) |=> state_q != $past(state_q))
    else $error("toggle did not toggle");

  // (RQ2) no edge, no change
  chk_no_edge_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ2
    (!clr_s && !fall_edge) |=> $stable(state_q))
    else $error("state moved without falling edge");

  // (RQ4) clear pulse clears
  chk_clear_pin: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ4
    $rose(direct_clear_i) ##0 direct_clear_i [*3] |=> !state_o && state_n_o)
    else $error("clear pulse did not clear");

  // (RQ6) clear beats clock edge
  chk_clear_wins: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ6
    (clr_s && fall_edge) |=> !state_q)
    else $error("clock edge beat active clear");

  // (RQ5) cleared toggles to set
  chk_clear_to_set: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ5
    (!state_q && !clr_s && fall_edge && !steer.first && !steer.second) |=> state_o)
    else $error("cleared state did not go to set");

  // (RQ4) outputs stay complementary
  chk_outs_compl: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ4
    state_o != state_n_o)
    else $error("outputs not complementary");

  // (RQ6) active clear keeps cleared
  chk_clear_holds: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ6
    clr_s |=> !state_o && state_n_o)
    else $error("state left cleared while clear active");

  // ************************************************************
  // pin to output checks
  // ************************************************************
  // a pin sampled at edge k reaches the state at edge k+2, so the
  // outputs are judged three edges after the pin was seen
  // (RQ1) set from the pins
  chk_pin_set: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ1
    ($fell(toggle_clk_i) && steer_first_i && !steer_second_i && !direct_clear_i) |-> ##3 state_o)
    else $error("pin level set not seen");

  // (RQ1) reset from the pins
  chk_pin_reset: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ1
    ($fell(toggle_clk_i) && !steer_first_i && steer_second_i && !direct_clear_i) |-> ##3 !state_o)
    else $error("pin level reset not seen");

  // (RQ1) hold from the pins
  chk_pin_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ1
    ($fell(toggle_clk_i) && steer_first_i && steer_second_i && !direct_clear_i) |-> ##3 $stable(state_o))
    else $error("pin level hold moved state");

  // (RQ1) toggle from the pins
  chk_pin_toggle: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ1
    ($fell(toggle_clk_i) && !steer_first_i && !steer_second_i && !direct_clear_i) |-> ##3 $changed(state_o))
    else $error("pin level toggle not seen");

  // (RQ2) rising clock is ignored
  chk_pin_rise: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ2
    ($rose(toggle_clk_i) && !direct_clear_i) |-> ##3 $stable(state_o))
    else $error("state moved on rising clock");

  // (RQ4) clear from the pin
  chk_pin_clear: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ4
    $rose(direct_clear_i) |-> ##3 (!state_o && state_n_o))
    else $error("pin level clear not seen");

  // ************************************************************
  // cover points
  // ************************************************************
  cov_toggle: cover property (@(posedge clk_i) disable iff (!rstn_i)
    fall_edge && !clr_s && act == ACT_TOGGLE);

  cov_set: cover property (@(posedge clk_i) disable iff (!rstn_i)
    fall_edge && !clr_s && act == ACT_SET);

  cov_clear_edge: cover property (@(posedge clk_i) disable iff (!rstn_i)
    fall_edge && clr_s && state_q);

  cov_reset: cover property (@(posedge clk_i) disable iff (!rstn_i)
    fall_edge && !clr_s && act == ACT_RESET);

  cov_hold: cover property (@(posedge clk_i) disable iff (!rstn_i)
    fall_edge && !clr_s && act == ACT_HOLD);

endmodule : jk_flip_flop_direct_clear
`default_nettype wire

// *** jk_pkg.sv ***
// Functional notes
// (RQ1) falling edge: hold, set, reset, toggle
// (RQ2) steering sampled only at falling edge
// (RQ3) clear held low for clocked operation
// (RQ4) clear pulse forces cleared state immediately; here the state clears two clk_i edges after the pin is sampled
// (RQ5) cleared, both low, edge gives set
// (RQ6) active clear overrides any clock edge
package jk_pkg;

  // steering pair as it is sampled at the falling edge
  typedef struct packed {
    logic first;
    logic second;
  } steer_s;

  typedef enum logic [1:0] {
    ACT_HOLD,
    ACT_SET,
    ACT_RESET,
    ACT_TOGGLE
  } action_e;

  localparam logic STATE_RESET_VAL = 1'b0;
  localparam int SYNC_STAGES = 2;

endpackage : jk_pkg

// *** jk_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module jk_sync
  import jk_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // refused at elaboration: a zero-width synchroniser carries nothing
  if (WIDTH < 1) begin : g_width_check
    $error("jk_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : jk_sync
`default_nettype wire

// *** jk_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module jk_partner
  import jk_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  output logic toggle_clk_o,
  output logic done_o
);
  logic [3:0] cnt_q = 4'h0;
  logic [3:0] cnt_d;
  always_comb begin
    cnt_d = cnt_q;
    if (go_i)
      cnt_d = 4'h1;
    else if (cnt_q != 4'h0)
      cnt_d = cnt_q + 4'h1;
    if (cnt_q == 4'h9)
      cnt_d = 4'h0;
  end
  always_ff @(posedge clk_i)
    cnt_q <= cnt_d;
  assign toggle_clk_o = !(cnt_q inside {[4'h1:4'h4]});
  assign done_o = (cnt_q == 4'h8);
endmodule : jk_partner
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench import jk_pkg::*;;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic first = 1'b1;
  logic second = 1'b1;
  logic clear = 1'b0;
  logic go = 1'b0;
  logic model = 1'b0;
  logic tclk, done, state, state_n, e;
  logic exp_q[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 61841;
  always #2 clk_i = ~clk_i;
  jk_flip_flop_direct_clear jk_flip_flop_direct_clear_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .steer_first_i(first), .steer_second_i(second), .toggle_clk_i(tclk),
    .direct_clear_i(clear), .state_o(state), .state_n_o(state_n));
  jk_partner jk_partner_i (.clk_i(clk_i), .go_i(go), .toggle_clk_o(tclk), .done_o(done));
  task automatic op(input steer_s v, input logic clr_fall = 1'b0);
    @(posedge clk_i);
    first <= v.first;
    second <= v.second;
    case ({v.first, v.second})
      2'b10: model = 1'b1;
      2'b01: model = 1'b0;
      2'b00: model = ~model;
      default: model = model;
    endcase
    if (clear || clr_fall)
      model = 1'b0;
    exp_q.push_back(model);
    repeat (3) @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    // clear rises with the clock fall so both reach the core at one edge
    if (clr_fall)
      clear <= 1'b1;
    repeat (5) @(posedge clk_i);
    // steering flips well after the fall and must be ignored
    first <= ~v.first;
    second <= ~v.second;
    repeat (5) @(posedge clk_i);
  endtask : op
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  always @(posedge clk_i) begin
    if (done === 1'b1) begin
      e = exp_q.pop_front();
      samples_checked++;
      if ({state, state_n} !== {e, ~e}) begin
        n_mismatch++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, {state, state_n}, {e, ~e});
      end
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    op(steer_s'(2'b10));
    clear <= 1'b1;
    op(steer_s'(2'b10));
    clear <= 1'b0;
    $display("test clear done");
    op(steer_s'(2'b00));
    $display("test set done");
    for (int i = 0; i < 4; i++)
      op(steer_s'(i[1:0]));
    $display("test codes done");
    op(steer_s'(2'b10), 1'b1);
    clear <= 1'b0;
    $display("test clear at fall done");
    for (int i = 0; i < 20; i++)
      op(steer_s'(2'($random(seed))));
    $display("test random done");
    close_out();
  end
  initial begin
    #16000;
    n_mismatch++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
